/* hdl/pdt_timer.sv */
// Purpose: 8-bit downcounter behind a 7-bit prescaler
// Assumes: Avalon-MM slave, one clock, inputs synchronous
// Notes:   One wait state on every bus access
//
// Contract
// R01 - Underflow 00h to FFh sets zero flag
// R02 - Software clears zero flag itself
// R03 - Request when enable and flag both set
// R04 - Interrupt enable resets cleared
// R05 - Run low holds prescaler 7Fh, count frozen
// R06 - Run high: prescaler and count decrement
// R07 - Select codes divide by 1 to 128
// R08 - Prescaler reg bits 6:0, bit 7 zero
// R09 - Count register full 8 bits, resets FFh
// R10 - Status/control resets 00h
// R11 - Software writes one to bit 5
// R12 - Software writes zero to bit 4
// R13 - Prescaler fed by core clock over 12
// R14 - Count reloads FFh after zero
// R15 - Count write beats decrement, no flag
// R16 - Enabled request wakes from wait
// R17 - Count decrements once per tap pulse
// R18 - Reserved bits stored, no counting effect
`timescale 1ns/1ps
`include "pdt_defines.svh"

module pdt_timer (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Register bus
    input  pdt_pkg::pdt_avm_req_t avm_req,
    output pdt_pkg::pdt_avm_rsp_t avm_rsp,
    // Interrupt and wake
    output logic               timer_irq,
    output logic               wake_req,
    output logic               irq
);
    import pdt_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [6:0]     prescaler;
    logic [7:0]     timer_count;
    pdt_ctrl_t      ctrl;
    logic [7:0]     irq_status;
    logic [7:0]     irq_mask;
    pdt_bus_state_t bus_state;
    logic [31:0]    rdata;
    logic [31:0]    next_rdata;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic [7:0] idx;
    logic       req;
    logic       acc;
    logic       wr;
    logic [7:0] wbyte;
    logic       wr_presc;
    logic       wr_count;
    logic       wr_ctrl;
    logic       wr_istat;
    logic       wr_imask;

    assign idx   = avm_req.address[9:2];
    assign req   = avm_req.read | avm_req.write;
    assign acc   = req & (bus_state == PDT_BUS_ACK);
    assign wr    = acc & avm_req.write & avm_req.byteenable[0];
    assign wbyte = avm_req.writedata[7:0];

    assign wr_presc = wr & (idx == `PDT_IDX_PRESC);
    assign wr_count = wr & (idx == `PDT_IDX_COUNT);
    assign wr_ctrl  = wr & (idx == `PDT_IDX_CTRL);
    assign wr_istat = wr & (idx == `PDT_IDX_ISTAT);
    assign wr_imask = wr & (idx == `PDT_IDX_IMASK);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_state <= PDT_BUS_IDLE;
        end else begin
            case (bus_state)
                PDT_BUS_IDLE: begin
                    if (req) begin
                        bus_state <= PDT_BUS_ACK;
                    end
                end
                PDT_BUS_ACK: begin
                    bus_state <= PDT_BUS_IDLE;
                end
                default: begin
                    bus_state <= PDT_BUS_IDLE;
                end
            endcase
        end
    end

    // Unmapped reads return zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (idx)
            `PDT_IDX_PRESC: next_rdata = {25'h0, prescaler}; // R08
            `PDT_IDX_COUNT: next_rdata = {24'h0, timer_count}; // R09
            `PDT_IDX_CTRL:  next_rdata = {24'h0, ctrl}; // R18
            `PDT_IDX_ISTAT: next_rdata = {24'h0, irq_status};
            `PDT_IDX_IMASK: next_rdata = {24'h0, irq_mask};
            default:        next_rdata = 32'h0000_0000;
        endcase
    end

    // Sampled in the wait cycle, stands until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (req && avm_req.read && bus_state == PDT_BUS_IDLE) begin
            rdata <= next_rdata;
        end
    end

    assign avm_rsp.readdata    = rdata;
    assign avm_rsp.waitrequest = req & (bus_state != PDT_BUS_ACK);

    // ----------------------------------------
    // Prescaler and tap select
    // ----------------------------------------
    logic       core_tick;
    logic       run_tick;
    logic [6:0] tap_mask;
    logic       tap_hit;
    logic       cnt_tick;
    logic       underflow;

    pdt_core_div u_div (
        .clk  (clk),
        .rst  (rst),
        .tick (core_tick)
    );

    // Tap n fires when the low n prescaler bits are zero
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_tap
            assign tap_mask[gi] = (ctrl.division_select > 3'(gi)); // R07
        end
    endgenerate

    assign run_tick = ctrl.prescaler_run & core_tick; // R06
    assign tap_hit  = ((prescaler & tap_mask) == 7'h00);
    assign cnt_tick = run_tick & tap_hit; // R17

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prescaler <= `PDT_RST_PRESC;
        end else if (!ctrl.prescaler_run) begin
            prescaler <= `PDT_RST_PRESC; // R05
        end else if (wr_presc) begin
            prescaler <= wbyte[6:0];
        end else if (run_tick) begin
            // 00h wraps to 7Fh on its own
            prescaler <= prescaler - 7'h01; // R13
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // A write in the same cycle suppresses the underflow
    assign underflow = cnt_tick & ~wr_count & (timer_count == 8'h00); // R15

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_count <= `PDT_RST_COUNT;
        end else if (wr_count) begin
            timer_count <= wbyte; // R15
        end else if (cnt_tick) begin
            // 00h rolls over to FFh
            timer_count <= timer_count - 8'h01; // R14
        end
    end

    // ----------------------------------------
    // Status/control
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= pdt_ctrl_t'(`PDT_RST_CTRL); // R10 R04
        end else begin
            if (wr_ctrl) begin
                ctrl <= pdt_ctrl_t'(wbyte); // R18
            end
            // Underflow wins over a clearing write
            if (underflow) begin
                ctrl.zero_flag <= 1'b1; // R01
            end
        end
    end

    // Reserved bits never reach the counting path
    assign timer_irq = ctrl.zero_flag & ctrl.zero_interrupt_enable; // R03
    assign wake_req  = timer_irq; // R16

    // ----------------------------------------
    // Sticky event status and mask
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= `PDT_RST_IRQ;
        end else begin
            if (wr_istat) begin
                irq_status <= irq_status & ~wbyte;
            end
            if (underflow) begin
                irq_status[`PDT_EV_UNDER] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask <= `PDT_RST_IRQ;
        end else if (wr_imask) begin
            irq_mask <= wbyte;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_zero_tick;
        cnt_tick && !wr_count && timer_count == 8'h00;
    endsequence

    sequence s_flag_set;
        ctrl.zero_flag && timer_count == 8'hff;
    endsequence

    chk_flag_on_under: assert property ( // R01
        s_zero_tick |=> s_flag_set
    ) else $error("zero flag not set on underflow");

    chk_reload_ff: assert property ( // R14
        s_zero_tick |=> timer_count == 8'hff
    ) else $error("count did not reload ff");

    chk_write_wins: assert property ( // R15
        (wr_count && cnt_tick && !ctrl.zero_flag && !wr_ctrl)
            |=> timer_count == $past(wbyte) && !ctrl.zero_flag
    ) else $error("count write lost to decrement");

    chk_irq_both: assert property ( // R03
        $rose(ctrl.zero_flag) && ctrl.zero_interrupt_enable |-> timer_irq && wake_req
    ) else $error("request missing with flag and enable");

    chk_irq_off: assert property ( // R03
        !ctrl.zero_interrupt_enable |-> !timer_irq
    ) else $error("request while enable low");

    chk_hold_stop: assert property ( // R05
        !ctrl.prescaler_run && !wr_count && !wr_ctrl
            |=> prescaler == 7'h7f && $stable(timer_count)
    ) else $error("counting while run low");

    chk_presc_dec: assert property ( // R06
        ctrl.prescaler_run && run_tick && !wr_presc && !wr_ctrl
            |=> prescaler == $past(prescaler) - 7'h01
    ) else $error("prescaler did not step down");

    chk_div_one: assert property ( // R17
        run_tick && ctrl.division_select == 3'h0 && !wr_count
            && timer_count != 8'h00 |=> timer_count == $past(timer_count) - 8'h01
    ) else $error("count missed a tap pulse");

    chk_div_128: assert property ( // R07
        cnt_tick && ctrl.division_select == 3'h7 |-> prescaler == 7'h00
    ) else $error("divide by 128 tap misplaced");

    chk_tick_space: assert property ( // R13
        core_tick |=> !core_tick [*8]
    ) else $error("core tick spacing wrong");

    chk_reset_vals: assert property ( // R10
        $fell(rst) |-> prescaler == 7'h7f && timer_count == 8'hff && ctrl == 8'h00
    ) else $error("wrong reset values");

    chk_enable_rst: assert property ( // R04
        $fell(rst) |-> !ctrl.zero_interrupt_enable && !timer_irq
    ) else $error("enable not cleared by reset");

    chk_presc_msb: assert property ( // R08
        $rose(bus_state == PDT_BUS_ACK) && avm_req.read && idx == `PDT_IDX_PRESC
            |-> rdata[7] == 1'b0
    ) else $error("prescaler bit 7 reads one");

    chk_tick_period: assert property ( // R13
        core_tick |-> ##12 core_tick
    ) else $error("core tick period not twelve");

    chk_flag_sticky: assert property ( // R02
        ctrl.zero_flag && !wr_ctrl |=> ctrl.zero_flag
    ) else $error("zero flag cleared by hardware");

    chk_flag_cause: assert property ( // R01
        !ctrl.zero_flag && !underflow && !wr_ctrl |=> !ctrl.zero_flag
    ) else $error("zero flag set without underflow");

    chk_count_hold: assert property ( // R17
        !cnt_tick && !wr_count |=> $stable(timer_count)
    ) else $error("count moved without tap pulse");

    chk_div_two: assert property ( // R07
        cnt_tick && ctrl.division_select == 3'h1 |-> !prescaler[0]
    ) else $error("divide by 2 tap misplaced");

    chk_wake_both: assert property ( // R16
        ctrl.zero_flag && ctrl.zero_interrupt_enable |-> wake_req
    ) else $error("wake missing with flag and enable");

    chk_irq_cause: assert property ( // R03
        timer_irq |-> ctrl.zero_flag && ctrl.zero_interrupt_enable
    ) else $error("request without flag and enable");

    chk_presc_wrap: assert property ( // R13
        run_tick && prescaler == 7'h00 && !wr_presc |=> prescaler == 7'h7f
    ) else $error("prescaler did not reload 7f");

    chk_event_sticky: assert property ( // R01
        underflow |=> irq_status[`PDT_EV_UNDER]
    ) else $error("underflow event not recorded");

    chk_count_write: assert property ( // R09
        wr_count |=> timer_count == $past(wbyte)
    ) else $error("count write not stored");

    chk_presc_write: assert property ( // R08
        wr_presc && ctrl.prescaler_run |=> prescaler == $past(wbyte[6:0])
    ) else $error("prescaler write not stored");

endmodule : pdt_timer

/* hdl/pdt_defines.svh */
// Purpose: Constants of the prescaled downcount timer
// Assumes: Included by its bare name
// Notes:   Register indices; byte address is four times the index
`ifndef PDT_DEFINES_SVH
`define PDT_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define PDT_IDX_PRESC 8'hd2
`define PDT_IDX_COUNT 8'hd3
`define PDT_IDX_CTRL  8'hd4
`define PDT_IDX_ISTAT 8'hd5
`define PDT_IDX_IMASK 8'hd6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDT_RST_PRESC 7'h7f
`define PDT_RST_COUNT 8'hff
`define PDT_RST_CTRL  8'h00
`define PDT_RST_IRQ   8'h00

// ----------------------------------------
// Fields and timing
// ----------------------------------------
`define PDT_EV_UNDER  0
`define PDT_CORE_DIV  4'hc

`endif

/* hdl/pdt_pkg.sv */
// Purpose: Types of the prescaled downcount timer
// Assumes: Avalon-MM slave with waitrequest
// Notes:   Constants live in pdt_defines.svh
package pdt_pkg;

    // ----------------------------------------
    // Bus carriers
    // ----------------------------------------
    typedef struct packed {
        logic [9:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } pdt_avm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } pdt_avm_rsp_t;

    // ----------------------------------------
    // Status/control layout, bit 7 first
    // ----------------------------------------
    typedef struct packed {
        logic       zero_flag;
        logic       zero_interrupt_enable;
        logic       reserved_set_bit;
        logic       reserved_clear_bit;
        logic       prescaler_run;
        logic [2:0] division_select;
    } pdt_ctrl_t;

    // ----------------------------------------
    // Bus slave states
    // ----------------------------------------
    typedef enum logic [1:0] {
        PDT_BUS_IDLE = 2'b01,
        PDT_BUS_ACK  = 2'b10
    } pdt_bus_state_t;

endpackage : pdt_pkg

/* hdl/pdt_core_div.sv */
// Purpose: Divide the core clock by twelve into an enable pulse
// Assumes: clk is the internal core clock
// Notes:   Free running from reset
`timescale 1ns/1ps
`include "pdt_defines.svh"

module pdt_core_div (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Enable out
    output logic      tick
);
    import pdt_pkg::*;

    logic [3:0] phase;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= 4'h0;
        end else if (phase == `PDT_CORE_DIV - 4'h1) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    // One pulse per twelve core clocks
    assign tick = (phase == `PDT_CORE_DIV - 4'h1); // R13

endmodule : pdt_core_div

/* dv/pdt_timer_tb_top.sv */
// Purpose: Self-checking bench of the prescaled downcount timer
// Assumes: One wait state per bus access, core tick every 12 clocks
// Notes:   Counts are derived from prescaler reads, so tick phase is free
`timescale 1ns/1ps
`include "pdt_defines.svh"

module pdt_timer_tb_top;
    import pdt_pkg::*;

    logic         clk;
    logic         rst;
    pdt_avm_req_t req;
    pdt_avm_rsp_t rsp;
    logic         timer_irq;
    logic         wake_req;
    logic         irq;
    int           n_errors;
    int           samples_checked;
    int           k;
    int           d;
    logic [7:0]   rdat;
    logic [7:0]   p;
    logic [7:0]   c;

    pdt_timer pdt_timer_i (
        .clk       (clk),
        .rst       (rst),
        .avm_req   (req),
        .avm_rsp   (rsp),
        .timer_irq (timer_irq),
        .wake_req  (wake_req),
        .irq       (irq)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Request held until waitrequest is seen low at a rising edge
    // A hang is ended by the watchdog
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be);
        @(posedge clk);
        req.address    <= {idx, 2'b00};
        req.write      <= w;
        req.read       <= ~w;
        req.writedata  <= {24'h0, wd};
        req.byteenable <= be;
        do begin
            @(posedge clk);
        end while (rsp.waitrequest !== 1'b0);
        rdat = rsp.readdata[7:0];
        req.read  <= 1'b0;
        req.write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd, 4'hf);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 4'hf);
        chk(rdat, exp);
    endtask : rd_chk

    // Align to a prescaler step so the count read sees the same tick
    task automatic sample();
        logic [7:0] p0;
        int         n;
        bus(1'b0, `PDT_IDX_PRESC, 8'h00, 4'hf);
        p0 = rdat;
        n  = 0;
        do begin
            bus(1'b0, `PDT_IDX_PRESC, 8'h00, 4'hf);
            n++;
        end while (rdat === p0 && n < 20);
        p = rdat;
        bus(1'b0, `PDT_IDX_COUNT, 8'h00, 4'hf);
        c = rdat;
    endtask : sample

    task automatic tally_and_finish();
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Watchdog, well beyond the ~13k cycles needed
    // ----------------------------------------
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst             = 1'b1;
        req             = '0;
        n_errors        = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({5'h0, timer_irq, wake_req, irq}, 8'h00);
        rd_chk(`PDT_IDX_PRESC, 8'h7f);
        rd_chk(`PDT_IDX_COUNT, 8'hff);
        rd_chk(`PDT_IDX_CTRL, 8'h00);
        rd_chk(`PDT_IDX_ISTAT, 8'h00);
        rd_chk(`PDT_IDX_IMASK, 8'h00);
        wr(8'he0, 8'h5a);
        rd_chk(8'he0, 8'h00);
        // Stopped: prescaler pinned, count frozen, reserved bits stored
        wr(`PDT_IDX_PRESC, 8'h11);
        rd_chk(`PDT_IDX_PRESC, 8'h7f);
        wr(`PDT_IDX_CTRL, 8'h20);
        repeat (40) @(posedge clk);
        rd_chk(`PDT_IDX_CTRL, 8'h20);
        rd_chk(`PDT_IDX_COUNT, 8'hff);
        bus(1'b1, `PDT_IDX_COUNT, 8'h12, 4'h0);
        rd_chk(`PDT_IDX_COUNT, 8'hff);
        wr(`PDT_IDX_COUNT, 8'ha5);
        rd_chk(`PDT_IDX_COUNT, 8'ha5);
        // Every division code over one full prescaler wrap
        for (int sel = 0; sel < 8; sel++) begin
            wr(`PDT_IDX_CTRL, 8'h20);
            wr(`PDT_IDX_COUNT, 8'hff);
            wr(`PDT_IDX_CTRL, 8'h28 | sel[7:0]);
            repeat (1600) @(posedge clk);
            sample();
            chk(p & 8'h80, 8'h00);
            k = 255 - int'(p);
            chk({7'h0, k >= 130 && k <= 137}, 8'h01);
            d = 0;
            for (int i = 0; i < k; i++) begin
                if ((((127 - i) & 127) & ((1 << sel) - 1)) == 0) d++;
            end
            chk(c, 8'hff - d[7:0]);
        end
        // Count writes every 5 clocks meet a tick at every phase; never underflows
        wr(`PDT_IDX_CTRL, 8'h28);
        for (int j = 0; j < 12; j++) begin
            wr(`PDT_IDX_COUNT, 8'h01);
            repeat (2) @(posedge clk);
        end
        // A tick may land right after the write
        wr(`PDT_IDX_PRESC, 8'h40);
        bus(1'b0, `PDT_IDX_PRESC, 8'h00, 4'hf);
        chk({7'h0, rdat == 8'h40 || rdat == 8'h3f}, 8'h01);
        wr(`PDT_IDX_CTRL, 8'h20);
        rd_chk(`PDT_IDX_CTRL, 8'h20);
        // Underflow, flag, interrupt and wake
        wr(`PDT_IDX_CTRL, 8'h20);
        wr(`PDT_IDX_COUNT, 8'h01);
        wr(`PDT_IDX_IMASK, 8'h01);
        wr(`PDT_IDX_CTRL, 8'h68);
        k = 0;
        while (timer_irq !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        chk({7'h0, timer_irq}, 8'h01);
        rd_chk(`PDT_IDX_COUNT, 8'hff);
        chk({5'h0, timer_irq, wake_req, irq}, 8'h07);
        rd_chk(`PDT_IDX_ISTAT, 8'h01);
        wr(`PDT_IDX_CTRL, 8'ha0);
        @(posedge clk);
        chk({7'h0, timer_irq}, 8'h00);
        rd_chk(`PDT_IDX_CTRL, 8'ha0);
        wr(`PDT_IDX_IMASK, 8'h00);
        @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        wr(`PDT_IDX_IMASK, 8'h01);
        @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        wr(`PDT_IDX_ISTAT, 8'h01);
        @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        rd_chk(`PDT_IDX_ISTAT, 8'h00);
        wr(`PDT_IDX_CTRL, 8'h20);
        @(posedge clk);
        chk({6'h0, timer_irq, wake_req}, 8'h00);
        rd_chk(`PDT_IDX_CTRL, 8'h20);
        tally_and_finish();
    end

endmodule : pdt_timer_tb_top
